// ===== rtl/chsi_dma_zero.sv
`timescale 1ns/1ps
module chsi_dma_zero
  import chsi_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic [15:0] cur_count,
  input  wire logic [15:0] next_count,
  output logic             both_zero
);
  // Level flag, follows counters with one register stage
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      both_zero <= 1'b0;
    else
      both_zero <= (cur_count == CHSI_DMA_ZERO) &&
                   (next_count == CHSI_DMA_ZERO);
  end
endmodule

// ===== rtl/chsi_pkg.sv
package chsi_pkg;
  // Register byte offsets, one aligned word each
  localparam logic [7:0] CHSI_OFS_COMMAND   = 8'h00;
  localparam logic [7:0] CHSI_OFS_STATUS    = 8'h04;
  localparam logic [7:0] CHSI_OFS_IRQ_EN    = 8'h08;
  localparam logic [7:0] CHSI_OFS_IRQ_DIS   = 8'h0c;
  localparam logic [7:0] CHSI_OFS_IRQ_MASK  = 8'h10;
  localparam logic [7:0] CHSI_OFS_RSP_INDEX = 8'h14;

  // Status and mask bit positions
  localparam int CHSI_B_CMD_DONE     = 0;
  localparam int CHSI_B_RX_WORD_RDY  = 1;
  localparam int CHSI_B_TX_WORD_TKN  = 2;
  localparam int CHSI_B_BLOCK_ENDED  = 3;
  localparam int CHSI_B_XFER_IN_PROG = 4;
  localparam int CHSI_B_CARD_NBUSY   = 5;
  localparam int CHSI_B_RX_DMA_DONE  = 6;
  localparam int CHSI_B_TX_DMA_DONE  = 7;
  localparam int CHSI_B_SLOT_A_IRQ   = 8;
  localparam int CHSI_B_SLOT_B_IRQ   = 9;
  localparam int CHSI_B_RX_BUF_FULL  = 14;
  localparam int CHSI_B_TX_BUF_EMPTY = 15;
  localparam int CHSI_B_RSP_INDEX    = 16;
  localparam int CHSI_B_RSP_DIR      = 17;
  localparam int CHSI_B_RSP_CRC      = 18;
  localparam int CHSI_B_RSP_END      = 19;
  localparam int CHSI_B_RSP_TIMEOUT  = 20;
  localparam int CHSI_B_DATA_CRC     = 21;
  localparam int CHSI_B_DATA_TIMEOUT = 22;
  localparam int CHSI_B_RX_OVERRUN   = 30;
  localparam int CHSI_B_TX_UNDERRUN  = 31;

  // Implemented bits of the shared layout
  localparam logic [31:0] CHSI_LAYOUT_MASK = 32'hc07f_c3ff;
  localparam logic [31:0] CHSI_MASK_RESET  = 32'h0000_0000;
  localparam logic [31:0] CHSI_ZERO_WORD   = 32'h0000_0000;
  localparam logic [15:0] CHSI_DMA_ZERO    = 16'h0000;
  localparam logic [5:0]  CHSI_INDEX_RESET = 6'h00;
endpackage

// ===== rtl/chsi_status_irq.sv
`timescale 1ns/1ps
// Summary of operation
// - Response timeout sets flag; command write clears
// - Data CRC failure sets flag; status read clears
// - Data timeout expiry sets flag; status read clears
// - Lost received byte sets overrun; new transfer clears
// - Unwritten byte sent sets underrun; new transfer clears
// - Slot A card interrupt sets flag; read clears
// - Slot B card interrupt sets flag; read clears
// - Receive full while both receive counters zero
// - Transmit empty while both transmit counters zero
// - Enable port ones enable, zeros no effect
// - Disable port ones disable, zeros no effect
// - Mask view reads enabled sources as one
// - Enable, disable, mask share one bit layout
// - Command sent sets done; command write clears
// - Response index mismatch sets flag; command write clears
module chsi_status_irq
  import chsi_pkg::*;
(
  input  wire logic        REF_CLK,
  input  wire logic        RESETN,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        CMD_SENT,
  input  wire logic        RSP_TIMEOUT,
  input  wire logic        RSP_RECEIVED,
  input  wire logic [5:0]  RSP_INDEX,
  input  wire logic        RSP_DIR_ERR,
  input  wire logic        RSP_CRC_ERR,
  input  wire logic        RSP_END_ERR,
  input  wire logic        DATA_CRC_FAIL,
  input  wire logic        DATA_TIMEOUT,
  input  wire logic        RX_BYTE_LOST,
  input  wire logic        TX_BYTE_EMPTY,
  input  wire logic        DATA_CMD_ISSUED,
  input  wire logic        SLOT_A_CARD_IRQ,
  input  wire logic        SLOT_B_CARD_IRQ,
  input  wire logic        RX_WORD_READY,
  input  wire logic        TX_WORD_TAKEN,
  input  wire logic        BLOCK_ENDED,
  input  wire logic        XFER_IN_PROGRESS,
  input  wire logic        CARD_NOT_BUSY,
  input  wire logic        RX_DMA_DONE,
  input  wire logic        TX_DMA_DONE,
  input  wire logic [15:0] RX_DMA_COUNTER,
  input  wire logic [15:0] RX_DMA_NEXT_COUNTER,
  input  wire logic [15:0] TX_DMA_COUNTER,
  input  wire logic [15:0] TX_DMA_NEXT_COUNTER,
  output logic             CMD_WRITE_STROBE,
  output logic [31:0]      CMD_WORD,
  output logic             IRQ
);
  logic        wr_access;
  logic        rd_access;
  logic        cmd_wr;
  logic        status_rd;
  logic [31:0] read_clr;
  logic        hit;
  logic [5:0]  cmd_index_reg;
  logic [31:0] mask_reg;
  logic [31:0] mask_next;
  logic [31:0] status_word;
  logic [31:0] rdata_next;
  logic [31:0] sticky;
  logic [31:0] sticky_set;
  logic [31:0] sticky_clr;
  logic        rx_full;
  logic        tx_empty;
  logic        rsp_index_bad;

  // Zero-wait slave: access phase completes in its first cycle
  assign wr_access = PSEL && PENABLE && PWRITE;
  assign rd_access = PSEL && PENABLE && !PWRITE;
  assign cmd_wr    = wr_access && (PADDR == CHSI_OFS_COMMAND);
  assign status_rd = rd_access && (PADDR == CHSI_OFS_STATUS);
  // Clear only what the read reported, so a late event is not lost
  assign read_clr  = status_rd ? PRDATA : CHSI_ZERO_WORD;

  always_comb
  begin
    hit = (PADDR == CHSI_OFS_COMMAND) || (PADDR == CHSI_OFS_STATUS) ||
          (PADDR == CHSI_OFS_IRQ_EN) || (PADDR == CHSI_OFS_IRQ_DIS) ||
          (PADDR == CHSI_OFS_IRQ_MASK) || (PADDR == CHSI_OFS_RSP_INDEX);
  end

  // Index of the command just written, compared with the response
  always_ff @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
      cmd_index_reg <= CHSI_INDEX_RESET;
    else if (cmd_wr)
      cmd_index_reg <= PWDATA[5:0];
  end

  always_ff @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      CMD_WRITE_STROBE <= 1'b0;
      CMD_WORD         <= CHSI_ZERO_WORD;
    end
    else
    begin
      CMD_WRITE_STROBE <= cmd_wr;
      if (cmd_wr)
        CMD_WORD <= PWDATA;
    end
  end

  assign rsp_index_bad = RSP_RECEIVED && (RSP_INDEX != cmd_index_reg);

  // Set and clear sources per sticky bit
  always_comb
  begin
    sticky_set = CHSI_ZERO_WORD;
    sticky_clr = CHSI_ZERO_WORD;
    sticky_set[CHSI_B_CMD_DONE]     = CMD_SENT;
    sticky_clr[CHSI_B_CMD_DONE]     = cmd_wr;
    sticky_set[CHSI_B_RSP_INDEX]    = rsp_index_bad;
    sticky_clr[CHSI_B_RSP_INDEX]    = cmd_wr;
    sticky_set[CHSI_B_RSP_DIR]      = RSP_DIR_ERR;
    sticky_clr[CHSI_B_RSP_DIR]      = cmd_wr;
    sticky_set[CHSI_B_RSP_CRC]      = RSP_CRC_ERR;
    sticky_clr[CHSI_B_RSP_CRC]      = cmd_wr;
    sticky_set[CHSI_B_RSP_END]      = RSP_END_ERR;
    sticky_clr[CHSI_B_RSP_END]      = cmd_wr;
    sticky_set[CHSI_B_RSP_TIMEOUT]  = RSP_TIMEOUT;
    sticky_clr[CHSI_B_RSP_TIMEOUT]  = cmd_wr;
    sticky_set[CHSI_B_DATA_CRC]     = DATA_CRC_FAIL;
    sticky_clr[CHSI_B_DATA_CRC]     = read_clr[CHSI_B_DATA_CRC];
    sticky_set[CHSI_B_DATA_TIMEOUT] = DATA_TIMEOUT;
    sticky_clr[CHSI_B_DATA_TIMEOUT] = read_clr[CHSI_B_DATA_TIMEOUT];
    sticky_set[CHSI_B_RX_OVERRUN]   = RX_BYTE_LOST;
    sticky_clr[CHSI_B_RX_OVERRUN]   = DATA_CMD_ISSUED;
    sticky_set[CHSI_B_TX_UNDERRUN]  = TX_BYTE_EMPTY;
    sticky_clr[CHSI_B_TX_UNDERRUN]  = DATA_CMD_ISSUED;
    sticky_set[CHSI_B_SLOT_A_IRQ]   = SLOT_A_CARD_IRQ;
    sticky_clr[CHSI_B_SLOT_A_IRQ]   = read_clr[CHSI_B_SLOT_A_IRQ];
    sticky_set[CHSI_B_SLOT_B_IRQ]   = SLOT_B_CARD_IRQ;
    sticky_clr[CHSI_B_SLOT_B_IRQ]   = read_clr[CHSI_B_SLOT_B_IRQ];
    sticky_set[CHSI_B_BLOCK_ENDED]  = BLOCK_ENDED;
    sticky_clr[CHSI_B_BLOCK_ENDED]  = read_clr[CHSI_B_BLOCK_ENDED];
  end

  genvar gi;
  generate
    for (gi = 0; gi < 32; gi++)
    begin : g_flag
      if (gi == CHSI_B_CMD_DONE || gi == CHSI_B_BLOCK_ENDED ||
          gi == CHSI_B_SLOT_A_IRQ || gi == CHSI_B_SLOT_B_IRQ ||
          (gi >= CHSI_B_RSP_INDEX && gi <= CHSI_B_DATA_TIMEOUT) ||
          gi == CHSI_B_RX_OVERRUN || gi == CHSI_B_TX_UNDERRUN)
      begin : g_sticky
        chsi_sticky_bit u_bit (
          .clk     (REF_CLK),
          .resetn  (RESETN),
          .set_evt (sticky_set[gi]),
          .clr_evt (sticky_clr[gi]),
          .flag    (sticky[gi])
        );
      end
      else
      begin : g_none
        assign sticky[gi] = 1'b0;
      end
    end
  endgenerate

  chsi_dma_zero u_rx_zero (
    .clk        (REF_CLK),
    .resetn     (RESETN),
    .cur_count  (RX_DMA_COUNTER),
    .next_count (RX_DMA_NEXT_COUNTER),
    .both_zero  (rx_full)
  );

  chsi_dma_zero u_tx_zero (
    .clk        (REF_CLK),
    .resetn     (RESETN),
    .cur_count  (TX_DMA_COUNTER),
    .next_count (TX_DMA_NEXT_COUNTER),
    .both_zero  (tx_empty)
  );

  // Level flags follow their sources; sticky bits hold events
  always_comb
  begin
    status_word = sticky;
    status_word[CHSI_B_RX_WORD_RDY]  = RX_WORD_READY;
    status_word[CHSI_B_TX_WORD_TKN]  = TX_WORD_TAKEN;
    status_word[CHSI_B_XFER_IN_PROG] = XFER_IN_PROGRESS;
    status_word[CHSI_B_CARD_NBUSY]   = CARD_NOT_BUSY;
    status_word[CHSI_B_RX_DMA_DONE]  = RX_DMA_DONE;
    status_word[CHSI_B_TX_DMA_DONE]  = TX_DMA_DONE;
    status_word[CHSI_B_RX_BUF_FULL]  = rx_full;
    status_word[CHSI_B_TX_BUF_EMPTY] = tx_empty;
  end

  // Enable and disable in one write cannot happen: separate offsets
  always_comb
  begin
    mask_next = mask_reg;
    if (wr_access && PADDR == CHSI_OFS_IRQ_EN)
      mask_next = mask_reg | (PWDATA & CHSI_LAYOUT_MASK);
    else if (wr_access && PADDR == CHSI_OFS_IRQ_DIS)
      mask_next = mask_reg & ~(PWDATA & CHSI_LAYOUT_MASK);
  end

  always_ff @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
      mask_reg <= CHSI_MASK_RESET;
    else
      mask_reg <= mask_next;
  end

  always_comb
  begin
    rdata_next = CHSI_ZERO_WORD;
    if (PSEL && !PENABLE && !PWRITE)
    begin
      unique case (PADDR)
        CHSI_OFS_STATUS:    rdata_next = status_word;
        CHSI_OFS_IRQ_MASK:  rdata_next = mask_reg;
        CHSI_OFS_RSP_INDEX: rdata_next = {26'h0, cmd_index_reg};
        default:            rdata_next = CHSI_ZERO_WORD;
      endcase
    end
  end

  // Read data registered in setup so it is valid in the access phase
  always_ff @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      PRDATA  <= CHSI_ZERO_WORD;
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
    end
    else
    begin
      PREADY  <= PSEL && !PENABLE;
      PSLVERR <= PSEL && !PENABLE && !hit;
      if (PSEL && !PENABLE && !PWRITE)
        PRDATA <= rdata_next;
    end
  end

  // Registered so the output comes from a flip-flop; one cycle late
  always_ff @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
      IRQ <= 1'b0;
    else
      IRQ <= |(status_word & mask_reg);
  end

  chk_irq_follows: assert property (
    @(posedge REF_CLK) disable iff (!RESETN)
    1'b1 |=> IRQ == |($past(status_word) & $past(mask_reg)))
    else $error("irq not following masked status");
  chk_enable_sets: assert property (
    @(posedge REF_CLK) disable iff (!RESETN)
    (wr_access && PADDR == CHSI_OFS_IRQ_EN) |=>
      ((mask_reg & ($past(PWDATA) & CHSI_LAYOUT_MASK)) ==
       ($past(PWDATA) & CHSI_LAYOUT_MASK)))
    else $error("enable write did not set mask");
  chk_disable_clears: assert property (
    @(posedge REF_CLK) disable iff (!RESETN)
    (wr_access && PADDR == CHSI_OFS_IRQ_DIS) |=>
      ((mask_reg & $past(PWDATA)) == CHSI_ZERO_WORD))
    else $error("disable write did not clear mask");
  chk_mask_stable: assert property (
    @(posedge REF_CLK) disable iff (!RESETN)
    !(wr_access && (PADDR == CHSI_OFS_IRQ_EN || PADDR == CHSI_OFS_IRQ_DIS))
      |=> $stable(mask_reg))
    else $error("mask changed without write");
  chk_rto_set: assert property (
    @(posedge REF_CLK) disable iff (!RESETN)
    RSP_TIMEOUT |=> status_word[CHSI_B_RSP_TIMEOUT])
    else $error("response timeout flag not set");
  chk_rto_clear: assert property (
    @(posedge REF_CLK) disable iff (!RESETN)
    (cmd_wr && !RSP_TIMEOUT) |=> !status_word[CHSI_B_RSP_TIMEOUT])
    else $error("timeout flag not cleared by command");
  chk_crc_sticky: assert property (
    @(posedge REF_CLK) disable iff (!RESETN)
    DATA_CRC_FAIL |=> status_word[CHSI_B_DATA_CRC])
    else $error("data crc flag not set");
  chk_crc_read: assert property (
    @(posedge REF_CLK) disable iff (!RESETN)
    (read_clr[CHSI_B_DATA_CRC] && !DATA_CRC_FAIL) |=>
      !status_word[CHSI_B_DATA_CRC])
    else $error("data crc flag not cleared by read");
  chk_dto_read: assert property (
    @(posedge REF_CLK) disable iff (!RESETN)
    (read_clr[CHSI_B_DATA_TIMEOUT] && !DATA_TIMEOUT) |=>
      !status_word[CHSI_B_DATA_TIMEOUT])
    else $error("data timeout not cleared by read");
  chk_ovr_hold: assert property (
    @(posedge REF_CLK) disable iff (!RESETN)
    (status_word[CHSI_B_RX_OVERRUN] && !DATA_CMD_ISSUED) |=>
      status_word[CHSI_B_RX_OVERRUN])
    else $error("overrun lost without new transfer");
  chk_unr_set: assert property (
    @(posedge REF_CLK) disable iff (!RESETN)
    TX_BYTE_EMPTY |=> status_word[CHSI_B_TX_UNDERRUN])
    else $error("underrun not set");
  chk_unr_clear: assert property (
    @(posedge REF_CLK) disable iff (!RESETN)
    (DATA_CMD_ISSUED && !TX_BYTE_EMPTY) |=>
      !status_word[CHSI_B_TX_UNDERRUN])
    else $error("underrun not cleared by new transfer");
  chk_slot_a_read: assert property (
    @(posedge REF_CLK) disable iff (!RESETN)
    (read_clr[CHSI_B_SLOT_A_IRQ] && !SLOT_A_CARD_IRQ) |=>
      !status_word[CHSI_B_SLOT_A_IRQ])
    else $error("slot a flag not cleared");
  chk_slot_b_set: assert property (
    @(posedge REF_CLK) disable iff (!RESETN)
    SLOT_B_CARD_IRQ |=> status_word[CHSI_B_SLOT_B_IRQ])
    else $error("slot b flag not set");
  chk_slot_b_read: assert property (
    @(posedge REF_CLK) disable iff (!RESETN)
    (read_clr[CHSI_B_SLOT_B_IRQ] && !SLOT_B_CARD_IRQ) |=>
      !status_word[CHSI_B_SLOT_B_IRQ])
    else $error("slot b flag not cleared");
  chk_rx_full: assert property (
    @(posedge REF_CLK) disable iff (!RESETN)
    1'b1 |=> rx_full == ($past(RX_DMA_COUNTER) == CHSI_DMA_ZERO &&
                         $past(RX_DMA_NEXT_COUNTER) == CHSI_DMA_ZERO))
    else $error("receive full flag wrong");
  chk_tx_empty: assert property (
    @(posedge REF_CLK) disable iff (!RESETN)
    1'b1 |=> tx_empty == ($past(TX_DMA_COUNTER) == CHSI_DMA_ZERO &&
                          $past(TX_DMA_NEXT_COUNTER) == CHSI_DMA_ZERO))
    else $error("transmit empty flag wrong");
  chk_mask_read: assert property (
    @(posedge REF_CLK) disable iff (!RESETN)
    (PSEL && !PENABLE && !PWRITE && PADDR == CHSI_OFS_IRQ_MASK) |=>
      PRDATA == $past(mask_reg))
    else $error("mask read data wrong");
  chk_cmd_done: assert property (
    @(posedge REF_CLK) disable iff (!RESETN)
    CMD_SENT |=> status_word[CHSI_B_CMD_DONE])
    else $error("command done not set");
  chk_cmd_clear: assert property (
    @(posedge REF_CLK) disable iff (!RESETN)
    (cmd_wr && !CMD_SENT) |=> !status_word[CHSI_B_CMD_DONE])
    else $error("command done not cleared by command");
  chk_index_err: assert property (
    @(posedge REF_CLK) disable iff (!RESETN)
    rsp_index_bad |=> status_word[CHSI_B_RSP_INDEX])
    else $error("index error not set");
endmodule

// ===== rtl/chsi_sticky_bit.sv
`timescale 1ns/1ps
module chsi_sticky_bit
  import chsi_pkg::*;
(
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic set_evt,
  input  wire logic clr_evt,
  output logic      flag
);
  // Set wins over a clear in the same cycle so no event is lost
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      flag <= 1'b0;
    else if (set_evt)
      flag <= 1'b1;
    else if (clr_evt)
      flag <= 1'b0;
  end
endmodule

// ===== testbench/chsi_card_engine.sv
`timescale 1ns/1ps
module chsi_card_engine
  import chsi_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic [31:0] evt_req,
  input  wire logic [5:0]  rsp_idx,
  output logic [31:0]      evt_q,
  output logic [5:0]       rsp_index
);
  // Events leave a register, so each request arrives clean and one cycle late
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      evt_q <= CHSI_ZERO_WORD;
    end
    else
    begin
      evt_q <= evt_req;
    end
  end

  // Index is valid only with its strobe; otherwise it keeps toggling
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rsp_index <= CHSI_INDEX_RESET;
    end
    else
    begin
      rsp_index <= evt_req[16] ? rsp_idx : ~rsp_index;
    end
  end
endmodule

// ===== testbench/chsi_status_irq_bench.sv
`timescale 1ns/1ps
module chsi_status_irq_bench
  import chsi_pkg::*;
;
  logic        ref_clk, resetn, psel, penable, pwrite, pready, pslverr;
  logic        irq, cmd_stb, er;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, cmd_word, evt_req, evt_q, rd, exp_w;
  logic [15:0] rxc, rxn, txc, txn;
  logic [5:0]  rsp_index, lvl;
  int          miscompares, cmp_count;

  chsi_status_irq dut_u (
    .REF_CLK(ref_clk), .RESETN(resetn), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .CMD_SENT(evt_q[0]),
    .RSP_TIMEOUT(evt_q[20]), .RSP_RECEIVED(evt_q[16]),
    .RSP_INDEX(rsp_index), .RSP_DIR_ERR(evt_q[17]),
    .RSP_CRC_ERR(evt_q[18]), .RSP_END_ERR(evt_q[19]),
    .DATA_CRC_FAIL(evt_q[21]), .DATA_TIMEOUT(evt_q[22]),
    .RX_BYTE_LOST(evt_q[30]), .TX_BYTE_EMPTY(evt_q[31]),
    .DATA_CMD_ISSUED(evt_q[29]), .SLOT_A_CARD_IRQ(evt_q[8]),
    .SLOT_B_CARD_IRQ(evt_q[9]), .RX_WORD_READY(lvl[0]),
    .TX_WORD_TAKEN(lvl[1]), .BLOCK_ENDED(evt_q[3]),
    .XFER_IN_PROGRESS(lvl[2]), .CARD_NOT_BUSY(lvl[3]),
    .RX_DMA_DONE(lvl[4]), .TX_DMA_DONE(lvl[5]), .RX_DMA_COUNTER(rxc),
    .RX_DMA_NEXT_COUNTER(rxn), .TX_DMA_COUNTER(txc),
    .TX_DMA_NEXT_COUNTER(txn), .CMD_WRITE_STROBE(cmd_stb),
    .CMD_WORD(cmd_word), .IRQ(irq)
  );

  chsi_card_engine card_u (
    .clk(ref_clk), .resetn(resetn), .evt_req(evt_req), .rsp_idx(6'h2a),
    .evt_q(evt_q), .rsp_index(rsp_index)
  );

  initial ref_clk = 1'b0;
  always #10 ref_clk = ~ref_clk;

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp,
                     input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Master waits for pready under a bound; no fixed answer time assumed
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1)
    begin
      miscompares++;
      report_and_stop();
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp,
                      input string nm);
    apb(1'b0, a, CHSI_ZERO_WORD);
    chk(nm, exp, rd);
  endtask

  task automatic fire(input logic [31:0] m);
    @(posedge ref_clk);
    evt_req <= m;
    @(posedge ref_clk);
    evt_req <= CHSI_ZERO_WORD;
    repeat (4) @(posedge ref_clk);
    #1;
  endtask

  // Clear kind: 0 status read, 1 command write, 2 new data command
  task automatic flag_case(input int b, input int k);
    logic [31:0] m;
    m = 32'h1 << b;
    wr(CHSI_OFS_IRQ_EN, m);
    fire(m);
    chk("irq raised", 32'h1, {31'h0, irq});
    rchk(CHSI_OFS_STATUS, m, "flag set");
    rchk(CHSI_OFS_STATUS, (k == 0) ? CHSI_ZERO_WORD : m, "flag kept");
    if (k == 1)
      wr(CHSI_OFS_COMMAND, 32'h0000_0011);
    if (k == 2)
      fire(32'h2000_0000);
    rchk(CHSI_OFS_STATUS, CHSI_ZERO_WORD, "flag cleared");
    repeat (2) @(posedge ref_clk);
    #1;
    chk("irq dropped", CHSI_ZERO_WORD, {31'h0, irq});
    wr(CHSI_OFS_IRQ_DIS, m);
  endtask

  initial
  begin
    miscompares = 0;
    cmp_count = 0;
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = CHSI_ZERO_WORD;
    evt_req = CHSI_ZERO_WORD;
    lvl = 6'h00;
    rxc = 16'h0001;
    rxn = 16'h0001;
    txc = 16'h0001;
    txn = 16'h0001;
    repeat (5) @(posedge ref_clk);
    resetn <= 1'b1;
    rchk(CHSI_OFS_IRQ_MASK, CHSI_MASK_RESET, "mask at reset");
    chk("irq at reset", CHSI_ZERO_WORD, {31'h0, irq});
    wr(CHSI_OFS_IRQ_EN, 32'hffff_ffff);
    rchk(CHSI_OFS_IRQ_MASK, CHSI_LAYOUT_MASK, "mask all");
    chk("mapped error", CHSI_ZERO_WORD, {31'h0, er});
    wr(CHSI_OFS_IRQ_EN, CHSI_ZERO_WORD);
    rchk(CHSI_OFS_IRQ_MASK, CHSI_LAYOUT_MASK, "mask en0");
    wr(CHSI_OFS_IRQ_DIS, 32'h8000_4001);
    rchk(CHSI_OFS_IRQ_MASK, 32'h407f_83fe, "mask part");
    wr(CHSI_OFS_IRQ_DIS, CHSI_ZERO_WORD);
    rchk(CHSI_OFS_IRQ_MASK, 32'h407f_83fe, "mask dis0");
    wr(CHSI_OFS_IRQ_DIS, 32'hffff_ffff);
    wr(CHSI_OFS_IRQ_MASK, 32'hffff_ffff);
    rchk(CHSI_OFS_IRQ_MASK, CHSI_ZERO_WORD, "mask read only");
    apb(1'b0, 8'h3c, CHSI_ZERO_WORD);
    chk("unmapped data", CHSI_ZERO_WORD, rd);
    chk("unmapped error", 32'h1, {31'h0, er});
    fire(32'h0000_0100);
    chk("masked irq", CHSI_ZERO_WORD, {31'h0, irq});
    apb(1'b0, CHSI_OFS_STATUS, CHSI_ZERO_WORD);
    wr(CHSI_OFS_COMMAND, 32'h0000_0011);
    @(posedge ref_clk);
    chk("command strobe", 32'h1, {31'h0, cmd_stb});
    chk("command word", 32'h0000_0011, cmd_word);
    flag_case(CHSI_B_CMD_DONE, 1);
    flag_case(CHSI_B_SLOT_A_IRQ, 0);
    flag_case(CHSI_B_SLOT_B_IRQ, 0);
    flag_case(CHSI_B_RSP_INDEX, 1);
    flag_case(CHSI_B_RSP_TIMEOUT, 1);
    flag_case(CHSI_B_DATA_CRC, 0);
    flag_case(CHSI_B_DATA_TIMEOUT, 0);
    flag_case(CHSI_B_RX_OVERRUN, 2);
    flag_case(CHSI_B_TX_UNDERRUN, 2);
    flag_case(CHSI_B_RSP_DIR, 1);
    flag_case(CHSI_B_RSP_CRC, 1);
    flag_case(CHSI_B_RSP_END, 1);
    flag_case(CHSI_B_BLOCK_ENDED, 0);
    wr(CHSI_OFS_COMMAND, 32'h0000_002a);
    fire(32'h0001_0000);
    rchk(CHSI_OFS_STATUS, CHSI_ZERO_WORD, "index match");
    @(posedge ref_clk);
    lvl <= 6'h3f;
    for (int i = 0; i < 4; i++)
    begin
      @(posedge ref_clk);
      rxc <= i[0] ? 16'h0001 : CHSI_DMA_ZERO;
      rxn <= i[1] ? 16'hffff : CHSI_DMA_ZERO;
      txc <= (i == 1) ? 16'h0001 : CHSI_DMA_ZERO;
      txn <= (i == 2) ? 16'hffff : CHSI_DMA_ZERO;
      repeat (3) @(posedge ref_clk);
      exp_w = 32'h0000_00f6 | ((i == 0) ? 32'h4000 : 32'h0);
      exp_w = exp_w | ((i == 0 || i == 3) ? 32'h8000 : 32'h0);
      rchk(CHSI_OFS_STATUS, exp_w, "buffers");
    end
    report_and_stop();
  end
endmodule
